// [core/usbs_pkg.sv]
// Shared constants for the host controller status register block
package usbs_pkg;
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned FI_W        = 14;
	// Status register byte offset from the memory base address
	localparam logic [7:0]  STATUS_OFFSET = 8'h24;
	// Status register field positions
	localparam int unsigned BIT_ASYNC_STATE    = 15;
	localparam int unsigned BIT_PERIODIC_STATE = 14;
	localparam int unsigned BIT_EMPTY_DETECT   = 13;
	localparam int unsigned BIT_HALTED         = 12;
	localparam int unsigned BIT_ADVANCE        = 5;
	localparam int unsigned BIT_HOST_ERR       = 4;
	localparam int unsigned BIT_ROLLOVER       = 3;
	localparam int unsigned BIT_PORT_CHANGE    = 2;
	localparam int unsigned BIT_TX_ERROR       = 1;
	localparam int unsigned BIT_TX_DONE        = 0;
	localparam int unsigned EVENT_W            = 6;
	// Reset values of the single-bit state fields and of the read data
	localparam logic        RST_HALTED   = 1'b1;
	localparam logic        RST_STATE    = 1'b0;
	localparam logic        RST_EVENT    = 1'b0;
	localparam logic [31:0] RST_RDATA    = 32'h0000_0000;
	// Frame list size encodings and the index bit that wraps for each
	localparam logic [1:0]  FLS_1024 = 2'h0;
	localparam logic [1:0]  FLS_512  = 2'h1;
	localparam logic [1:0]  FLS_256  = 2'h2;
	localparam int unsigned WRAP_BIT_1024 = 13;
	localparam int unsigned WRAP_BIT_512  = 12;
	localparam int unsigned WRAP_BIT_256  = 11;
endpackage

// [core/usbs_sched_track.sv]
// Reported run state of one schedule, lagging its enable control
`timescale 1ns/1ps
`default_nettype none
module usbs_sched_track (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_enable,
	input  wire logic i_running,
	output logic      o_state
);
	import usbs_pkg::*;

	typedef struct packed {
		logic state;
	} usbs_track_t;

	usbs_track_t s_q;
	usbs_track_t s_d;

	// Follow the enable only once the engine agrees with it
	always_comb begin
		s_d = s_q;
		if (i_running == i_enable) begin
			s_d.state = i_enable;
		end
	end

	// Reset to idle
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_q.state <= RST_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_state = s_q.state;
endmodule
`default_nettype wire

// [core/usbs_port_detect.sv]
// Port change detection over all root ports
`timescale 1ns/1ps
`default_nettype none
module usbs_port_detect #(
	parameter int unsigned PORTS = 2
) (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [PORTS-1:0] i_change,
	input  wire logic [PORTS-1:0] i_companion_owned,
	input  wire logic [PORTS-1:0] i_force_resume,
	input  wire logic [PORTS-1:0] i_resume_jk,
	output logic                  o_set,
	output logic                  o_any
);
	import usbs_pkg::*;

	typedef struct packed {
		logic [PORTS-1:0] chg_prev;
		logic [PORTS-1:0] fr_prev;
		logic             set;
		logic             any;
	} usbs_port_t;

	usbs_port_t s_q;
	usbs_port_t s_d;

	// Rising edges only; a change bit held high reports once
	always_comb begin
		s_d          = s_q;
		s_d.chg_prev = i_change;
		s_d.fr_prev  = i_force_resume;
		s_d.set      = 1'b0;
		for (int p = 0; p < PORTS; p++) begin
			if (!i_companion_owned[p] && i_change[p] && !s_q.chg_prev[p]) begin
				s_d.set = 1'b1;
			end
			if (i_force_resume[p] && !s_q.fr_prev[p] && i_resume_jk[p]) begin
				s_d.set = 1'b1;
			end
		end
		// Summary used when power returns from the deep sleep state
		s_d.any = |(i_change | i_force_resume);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_set = s_q.set;
	assign o_any = s_q.any;
endmodule
`default_nettype wire

// [core/usbs_status.sv]
// Host controller status register with its event and state tracking
// Operation
// - Bit 15 shows async schedule running, resets 0
// - Async state follows enable once really changed
// - Bit 14 shows periodic schedule running, resets 0
// - Periodic state follows enable once really changed
// - Bit 13 read-only empty async pass flag
// - Halted resets 1, reads 0 while running
// - Halted sets only after engine really stopped
// - Doorbell sets bit 5 at next advance
// - Bit 4 sets on host system error
// - Host system error clears run/stop
// - Bit 3 sets when frame index wraps
// - Wrap bit chosen by frame list size
// - Bit 2 sets on non-companion port change
// - Port flag also sets on J-K resume
// - Deep sleep wake reloads OR of changes
// - Bit 1 sets on transaction error
// - Error with completion request sets both flags
// - Bit 0 sets on retiring completion-request descriptor
// - Bit 0 also sets on short packet
// - Enabled events raise interrupt, all stay visible
`timescale 1ns/1ps
`default_nettype none
module usbs_status #(
	parameter int unsigned PORTS = 2
) (
	input  wire logic                        i_clk,
	input  wire logic                        i_sys_rst,
	// Register access port
	input  wire logic [usbs_pkg::ADDR_W-1:0] i_reg_addr,
	input  wire logic                        i_reg_wr,
	input  wire logic                        i_reg_rd,
	input  wire logic [usbs_pkg::DATA_W-1:0] i_reg_wdata,
	output logic      [usbs_pkg::DATA_W-1:0] o_reg_rdata,
	// Command register controls
	input  wire logic                        i_run_stop,
	input  wire logic                        i_async_sched_enable,
	input  wire logic                        i_periodic_sched_enable,
	input  wire logic                        i_doorbell_write,
	input  wire logic [1:0]                  i_frame_list_size,
	input  wire logic [5:0]                  i_intr_enable,
	output logic                             o_run_stop_clear,
	output logic                             o_doorbell_done,
	// Schedule engine reports
	input  wire logic                        i_async_running,
	input  wire logic                        i_periodic_running,
	input  wire logic                        i_engine_idle,
	input  wire logic                        i_async_empty_detect,
	input  wire logic                        i_async_advanced,
	input  wire logic                        i_host_sys_error,
	input  wire logic                        i_td_retire,
	input  wire logic                        i_td_ioc,
	input  wire logic                        i_td_error,
	input  wire logic                        i_short_packet,
	// Frame counter
	input  wire logic [usbs_pkg::FI_W-1:0]   i_frame_index,
	// Port logic
	input  wire logic [PORTS-1:0]            i_port_change,
	input  wire logic [PORTS-1:0]            i_companion_owned,
	input  wire logic [PORTS-1:0]            i_force_resume,
	input  wire logic [PORTS-1:0]            i_resume_jk,
	input  wire logic                        i_d3_to_d0,
	// Status outputs
	output logic                             o_halted_flag,
	output logic                             o_intr
);
	import usbs_pkg::*;

	// Register port timing
	// Strobe, address and data taken at one rising edge
	// Read data stands for exactly the next cycle
	// Read data is zero in every other cycle
	// A read and a write together return the old image
	// No wait state and no acknowledge on this port
	// Writes to any other address change nothing
	// Only full 32-bit words are read or written

	// Reset
	// Synchronous, active high, one edge is enough
	// All flags and pulses low, halted high, read data zero
	// First access may come the edge after release

	// Event timing
	// Engine pulse at edge N shows in the image after N
	// Port events pass an edge detector, one edge more
	// Interrupt output follows the image one edge later
	// Set beats clear when both fall in one cycle
	// An engine error or completion pulse held high sets its flag every cycle
	// Software clears a flag by writing one to its bit
	// Flags hold until software clears them; bit 2 can also be replaced by a wake reload

	// Halted flag
	// Cleared the edge after run/stop is seen high
	// Set only once run/stop is low and the engine idle
	// Idle while run/stop is still high is no halt
	// Resets high, as the engine is stopped after reset

	// Schedule state bits
	// Each follows its enable only when the engine agrees
	// Between the two, the old state is kept on purpose
	// Software polls these to know a change took effect

	// Doorbell
	// A ring waits for the next advance of the async schedule
	// Rings while one is pending merge into one completion
	// An advance with no ring pending is ignored
	// Completion pulse lets the command side drop its bit

	// Command side requests
	// Run/stop clear pulses the edge after each error cycle
	// Doorbell done pulses once at the serving advance
	// The command register owns both bits; this block asks

	// Frame list rollover
	// Watches the index bit just above the list entry field
	// Every toggle of that bit is one wrap of the list
	// Size code 3 is not defined and is taken as 1024
	// Changing the size while running can look like a wrap

	// Port change
	// Change bits count only for ports owned by this controller
	// Change bits report on their rising edge only
	// A change bit held high reports once
	// Wake from deep sleep reloads the OR of all change and force resume bits
	// That reload ignores owners; ownership may move in sleep

	// Interrupt
	// Any enabled flag raises the request
	// Disabled flags still read back for polling
	// Request drops the edge after the last enabled flag clears

	// Known limits
	// Frame index is expected to start at zero after reset
	// A start with the watched wrap bit set shows as one false rollover
	// Empty-detect bit mirrors the engine one cycle late
	// Reserved write bits are ignored, reserved read bits zero
	// Port inputs come from logic on this clock, no synchroniser

	// State of the block outside the trackers and port detector, registered in one place
	typedef struct packed {
		logic              halted;
		logic              empty_det;
		logic              advance;
		logic              host_err;
		logic              rollover;
		logic              port_chg;
		logic              tx_err;
		logic              tx_done;
		// Handshake, edge history and registered outputs
		logic              bell_pend;
		logic              wrap_prev;
		logic              run_clr;
		logic              bell_done;
		logic              intr;
		logic [DATA_W-1:0] rdata;
	} usbs_main_t;

	usbs_main_t s_q;
	usbs_main_t s_d;

	// Glue between the trackers, detector and state
	logic async_state;
	logic periodic_state;
	logic port_set;
	logic port_any;
	logic hit;
	logic [EVENT_W-1:0] clr;
	logic [EVENT_W-1:0] events;
	logic [EVENT_W-1:0] held;
	logic [DATA_W-1:0]  status_word;
	logic wrap_now;

	// Index bit that toggles at the wrap for the programmed list size
	function automatic logic wrap_bit(input logic [1:0] frame_list_size,
			input logic [FI_W-1:0] fi);
		logic b;
		b = fi[WRAP_BIT_1024];
		unique case (frame_list_size)
			FLS_1024: b = fi[WRAP_BIT_1024];
			FLS_512:  b = fi[WRAP_BIT_512];
			FLS_256:  b = fi[WRAP_BIT_256];
			default:  b = fi[WRAP_BIT_1024]; // Undefined code 3
		endcase
		return b;
	endfunction

	// Lagging schedule state trackers
	// Both schedules share one tracker design
	usbs_sched_track u_async (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_enable  (i_async_sched_enable),
		.i_running (i_async_running),
		.o_state   (async_state)
	);

	usbs_sched_track u_periodic (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_enable  (i_periodic_sched_enable),
		.i_running (i_periodic_running),
		.o_state   (periodic_state)
	);

	// Edge detection and wake summary for the root ports
	usbs_port_detect #(
		.PORTS (PORTS)
	) u_ports (
		.i_clk             (i_clk),
		.i_sys_rst         (i_sys_rst),
		.i_change          (i_port_change),
		.i_companion_owned (i_companion_owned),
		.i_force_resume    (i_force_resume),
		.i_resume_jk       (i_resume_jk),
		.o_set             (port_set),
		.o_any             (port_any)
	);

	// Decode and write-one-clear strobes; reserved write data ignored
	assign hit = i_reg_addr == STATUS_OFFSET;
	assign clr = (i_reg_wr && hit) ? i_reg_wdata[EVENT_W-1:0] : '0;
	assign wrap_now = wrap_bit(i_frame_list_size, i_frame_index);

	// Assembled register image, reserved bits read zero
	always_comb begin
		status_word = '0;
		status_word[BIT_ASYNC_STATE]    = async_state;
		status_word[BIT_PERIODIC_STATE] = periodic_state;
		status_word[BIT_EMPTY_DETECT]   = s_q.empty_det;
		status_word[BIT_HALTED]         = s_q.halted;
		status_word[BIT_ADVANCE]        = s_q.advance;
		status_word[BIT_HOST_ERR]       = s_q.host_err;
		status_word[BIT_ROLLOVER]       = s_q.rollover;
		status_word[BIT_PORT_CHANGE]    = s_q.port_chg;
		status_word[BIT_TX_ERROR]       = s_q.tx_err;
		status_word[BIT_TX_DONE]        = s_q.tx_done;
	end

	// Event flags as they read back
	assign events = status_word[EVENT_W-1:0];

	// Flags that survive this cycle's write-one-clear
	for (genvar g = 0; g < EVENT_W; g++) begin : g_hold
		assign held[g] = events[g] & ~clr[g];
	end

	// Next state: every event flag lets a new set beat a same-cycle clear
	always_comb begin
		s_d = s_q;
		s_d.run_clr   = 1'b0;
		s_d.bell_done = 1'b0;
		s_d.wrap_prev = wrap_now;
		s_d.empty_det = i_async_empty_detect;

		// Halted only after the engine has drained with run/stop low
		// Run/stop high wins at once, so a restart never waits
		// Idle alone means nothing while run/stop is high
		if (i_run_stop) begin
			s_d.halted = 1'b0;
		end else if (i_engine_idle) begin
			s_d.halted = 1'b1;
		end

		// Doorbell waits for the next advance of the async schedule
		if (i_doorbell_write) begin
			s_d.bell_pend = 1'b1;
		end
		// A ring while one is pending merges with it
		s_d.advance = held[BIT_ADVANCE];
		if (s_q.bell_pend && i_async_advanced) begin
			s_d.advance   = 1'b1;
			s_d.bell_pend = 1'b0;
			s_d.bell_done = 1'b1;
		end

		// Host system error also stops the schedule engine
		// Stop request repeats while the error input stays high
		s_d.host_err = held[BIT_HOST_ERR];
		if (i_host_sys_error) begin
			s_d.host_err = 1'b1;
			s_d.run_clr  = 1'b1;
		end

		// Rollover on each toggle of the wrap bit
		// A toggle in the clearing cycle still sets the flag
		s_d.rollover = (wrap_now != s_q.wrap_prev)
			| held[BIT_ROLLOVER];

		// Port change, or reload of the summary at wake from deep sleep
		// The wake reload replaces any stale flag
		if (i_d3_to_d0) begin
			s_d.port_chg = port_any | port_set;
		end else begin
			s_d.port_chg = port_set
				| held[BIT_PORT_CHANGE];
		end

		// Transaction completion events
		// An error on a completion-request descriptor sets both
		s_d.tx_err = (i_td_retire & i_td_error)
			| held[BIT_TX_ERROR];
		s_d.tx_done = (i_td_retire & i_td_ioc)
			| i_short_packet
			| held[BIT_TX_DONE];

		// Interrupt from enabled flags; disabled ones still read back
		// Taken from the image, so one edge after the flag
		s_d.intr = |(events & i_intr_enable);

		// Registered read data, zero for any other address
		// Zero between reads keeps a shared read bus simple
		s_d.rdata = (i_reg_rd && hit) ? status_word : RST_RDATA;
	end

	// Synchronous reset of the whole state
	// Flags and pulses low, halted high as nothing runs
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_q           <= '0;
			s_q.halted    <= RST_HALTED;
			s_q.advance   <= RST_EVENT;
			s_q.host_err  <= RST_EVENT;
			s_q.rollover  <= RST_EVENT;
			s_q.port_chg  <= RST_EVENT;
			s_q.tx_err    <= RST_EVENT;
			s_q.tx_done   <= RST_EVENT;
			s_q.rdata     <= RST_RDATA;
		end else begin
			s_q <= s_d;
		end
	end

	// Ports straight from the state register
	assign o_reg_rdata      = s_q.rdata;
	assign o_run_stop_clear = s_q.run_clr;
	assign o_doorbell_done  = s_q.bell_done;
	assign o_halted_flag    = s_q.halted;
	assign o_intr           = s_q.intr;
endmodule
`default_nettype wire

// [verification/usbs_status_asserts.sv]
// Concurrent checks on the status register block ports
`timescale 1ns/1ps
`default_nettype none
module usbs_status_asserts (
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_rd,
	input  wire logic [31:0] o_reg_rdata,
	input  wire logic        i_run_stop,
	input  wire logic        i_engine_idle,
	input  wire logic        i_async_sched_enable,
	input  wire logic        i_async_running,
	input  wire logic        i_doorbell_write,
	input  wire logic        i_async_advanced,
	input  wire logic        i_host_sys_error,
	input  wire logic        i_td_retire,
	input  wire logic        i_td_error,
	input  wire logic [5:0]  i_intr_enable,
	input  wire logic        o_run_stop_clear,
	input  wire logic        o_doorbell_done,
	input  wire logic        o_halted_flag,
	input  wire logic        o_intr
);
	import usbs_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Status read strobe at the one mapped offset
	logic rd_st;
	assign rd_st = i_reg_rd && i_reg_addr == STATUS_OFFSET;
	// Enable and real run state agreeing over two edges
	sequence s_settled;
		(i_async_sched_enable == i_async_running) [*2];
	endsequence
	// Doorbell rung, then the schedule advances
	sequence s_ring_adv;
		i_doorbell_write ##1 i_async_advanced;
	endsequence
	chk_halt_run: assert property (i_run_stop |=> !o_halted_flag)
		else $error("halted flag high while running");
	chk_halt_set: assert property (
		!i_run_stop && i_engine_idle |=> o_halted_flag)
		else $error("halted flag not set once idle");
	chk_halt_cause: assert property (
		$rose(o_halted_flag) |-> $past(i_engine_idle) && !$past(i_run_stop))
		else $error("halted flag set while engine busy");
	chk_rd_halt: assert property (
		rd_st |=> o_reg_rdata[BIT_HALTED] == $past(o_halted_flag))
		else $error("read halted bit differs from flag");
	chk_async_state: assert property (
		s_settled ##0 rd_st |=>
		o_reg_rdata[BIT_ASYNC_STATE] == $past(i_async_running, 2))
		else $error("async state bit not following settled state");
	chk_hse_stop: assert property (
		i_host_sys_error |=> o_run_stop_clear)
		else $error("host error did not stop the controller");
	chk_door_done: assert property (s_ring_adv |=> o_doorbell_done)
		else $error("advance after doorbell gave no completion");
	chk_done_cause: assert property (
		o_doorbell_done |-> $past(i_async_advanced))
		else $error("doorbell completion without an advance");
	chk_err_intr: assert property (
		i_td_retire && i_td_error && i_intr_enable[1] ##1 i_intr_enable[1]
		|=> o_intr)
		else $error("enabled error event raised no interrupt");
	chk_rd_quiet: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
endmodule
`default_nettype wire
bind usbs_status usbs_status_asserts u_chk (
	.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_rd, .o_reg_rdata, .i_run_stop,
	.i_engine_idle, .i_async_sched_enable, .i_async_running,
	.i_doorbell_write, .i_async_advanced, .i_host_sys_error, .i_td_retire,
	.i_td_error, .i_intr_enable, .o_run_stop_clear, .o_doorbell_done,
	.o_halted_flag, .o_intr
);

// [verification/test_usbs_status.sv]
// Self-checking bench for the status register block
`timescale 1ns/1ps
`default_nettype none
module test_usbs_status;
	import usbs_pkg::*;
	logic        i_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_run_stop;
	logic        i_async_sched_enable, i_periodic_sched_enable;
	logic        i_doorbell_write, i_async_running, i_periodic_running;
	logic        i_engine_idle, i_async_empty_detect, i_async_advanced;
	logic        i_host_sys_error, i_td_retire, i_td_ioc, i_td_error;
	logic        i_short_packet, i_d3_to_d0;
	logic        o_run_stop_clear, o_doorbell_done, o_halted_flag, o_intr;
	logic [7:0]  i_reg_addr;
	logic [31:0] i_reg_wdata, o_reg_rdata;
	logic [1:0]  i_frame_list_size, i_port_change, i_companion_owned;
	logic [1:0]  i_force_resume, i_resume_jk;
	logic [5:0]  i_intr_enable;
	logic [13:0] i_frame_index;
	int          bad_count = 0;
	int          checks_done = 0;

	usbs_status #(.PORTS(2)) DUT (
		.i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
		.o_reg_rdata, .i_run_stop, .i_async_sched_enable,
		.i_periodic_sched_enable, .i_doorbell_write, .i_frame_list_size,
		.i_intr_enable, .o_run_stop_clear, .o_doorbell_done,
		.i_async_running, .i_periodic_running, .i_engine_idle,
		.i_async_empty_detect, .i_async_advanced, .i_host_sys_error,
		.i_td_retire, .i_td_ioc, .i_td_error, .i_short_packet,
		.i_frame_index, .i_port_change, .i_companion_owned, .i_force_resume,
		.i_resume_jk, .i_d3_to_d0, .o_halted_flag, .o_intr
	);

	// Free-running 100 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task wrap_up;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s,
			input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	// Inputs move 1 ns after the edge so sampling never races
	task cyc(input int n = 1);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// Read strobe drops for a cycle so back-to-back calls never re-drive it
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
			input string n);
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		cyc();
		i_reg_rd = 1'b0;
		chk(n, o_reg_rdata, e);
		cyc();
	endtask

	task automatic rs(input logic [31:0] e);
		rd(STATUS_OFFSET, e, "status");
	endtask

	task automatic wr(input logic [31:0] d);
		i_reg_addr = STATUS_OFFSET;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		cyc();
		i_reg_wr = 1'b0;
		cyc();
	endtask

	// One event flag: visible, kept by a zero write, cleared by a one
	task automatic ev(input int b);
		logic [31:0] m;
		m = 32'h1 << b;
		rs(m);
		wr(32'h0);
		rs(m);
		wr(m);
		rs(32'h0);
	endtask

	// Hang guard, far beyond the few hundred cycles the tests use
	initial begin
		#20000;
		bad_count++;
		wrap_up();
	end

	initial begin
		{i_reg_wr, i_reg_rd, i_run_stop, i_async_sched_enable,
			i_periodic_sched_enable, i_doorbell_write, i_async_running,
			i_periodic_running, i_engine_idle, i_async_empty_detect,
			i_async_advanced, i_host_sys_error, i_td_retire, i_td_ioc,
			i_td_error, i_short_packet, i_d3_to_d0} = '0;
		{i_reg_addr, i_reg_wdata, i_frame_list_size, i_port_change} = '0;
		{i_companion_owned, i_force_resume, i_resume_jk} = '0;
		{i_intr_enable, i_frame_index} = '0;
		i_sys_rst = 1'b1;
		cyc(4);
		i_sys_rst = 1'b0;
		rs(32'h0000_1000);
		rd(8'h28, 32'h0, "unmapped");
		wr(32'h0000_f03f);
		rs(32'h0000_1000);
		i_run_stop = 1'b1;
		cyc();
		rs(32'h0);
		// Schedules enabled but not yet really running
		i_async_sched_enable = 1'b1;
		i_periodic_sched_enable = 1'b1;
		cyc(3);
		rs(32'h0);
		i_async_running = 1'b1;
		cyc();
		rs(32'h8000);
		i_periodic_running = 1'b1;
		cyc();
		rs(32'hc000);
		i_async_sched_enable = 1'b0;
		i_periodic_sched_enable = 1'b0;
		cyc(2);
		rs(32'hc000);
		i_async_running = 1'b0;
		i_periodic_running = 1'b0;
		cyc();
		rs(32'h0);
		i_async_empty_detect = 1'b1;
		cyc();
		wr(32'h2000);
		rs(32'h2000);
		i_async_empty_detect = 1'b0;
		// Completion, short packet, error and both together
		{i_td_retire, i_td_ioc} = 2'b11;
		cyc();
		{i_td_retire, i_td_ioc} = 2'b00;
		ev(0);
		i_short_packet = 1'b1;
		cyc();
		i_short_packet = 1'b0;
		ev(0);
		{i_td_retire, i_td_error} = 2'b11;
		cyc();
		{i_td_retire, i_td_error} = 2'b00;
		ev(1);
		{i_td_retire, i_td_ioc, i_td_error} = 3'b111;
		cyc();
		{i_td_retire, i_td_ioc, i_td_error} = 3'b000;
		rs(32'h3);
		wr(32'h3);
		i_host_sys_error = 1'b1;
		cyc();
		i_host_sys_error = 1'b0;
		chk("stop request", o_run_stop_clear, 32'h1);
		ev(4);
		// Rollover per frame list size
		i_frame_index = 14'h2000;
		cyc();
		ev(3);
		i_frame_index = 14'h3000;
		cyc();
		rs(32'h0);
		i_frame_list_size = FLS_512;
		i_frame_index = 14'h2000;
		cyc();
		ev(3);
		i_frame_list_size = FLS_256;
		i_frame_index = 14'h2800;
		cyc();
		ev(3);
		i_frame_list_size = 2'h3;
		cyc();
		rs(32'h0);
		i_frame_index = 14'h0800;
		cyc();
		ev(3);
		// Port changes: own port, companion port, resume, power return
		i_port_change = 2'b01;
		cyc(2);
		ev(2);
		i_port_change = 2'b10;
		i_companion_owned = 2'b10;
		cyc(3);
		rs(32'h0);
		{i_force_resume, i_resume_jk} = 4'b0101;
		cyc(2);
		ev(2);
		{i_force_resume, i_resume_jk} = 4'b0000;
		i_d3_to_d0 = 1'b1;
		cyc();
		i_d3_to_d0 = 1'b0;
		cyc();
		ev(2);
		// An advance with no doorbell pending is ignored
		i_async_advanced = 1'b1;
		cyc();
		i_async_advanced = 1'b0;
		rs(32'h0);
		i_doorbell_write = 1'b1;
		cyc();
		i_doorbell_write = 1'b0;
		i_async_advanced = 1'b1;
		cyc();
		i_async_advanced = 1'b0;
		chk("doorbell done", o_doorbell_done, 32'h1);
		ev(5);
		// Interrupt raised, masked, unmasked and acknowledged
		i_intr_enable = 6'h02;
		{i_td_retire, i_td_error} = 2'b11;
		cyc();
		{i_td_retire, i_td_error} = 2'b00;
		cyc();
		chk("intr", o_intr, 32'h1);
		i_intr_enable = 6'h3d;
		cyc(2);
		chk("intr masked", o_intr, 32'h0);
		rs(32'h2);
		i_intr_enable = 6'h02;
		cyc(2);
		chk("intr unmasked", o_intr, 32'h1);
		wr(32'h2);
		chk("intr cleared", o_intr, 32'h0);
		// Stop: halted waits for the engine to go idle
		i_run_stop = 1'b0;
		cyc(2);
		chk("halted busy", o_halted_flag, 32'h0);
		i_engine_idle = 1'b1;
		cyc();
		chk("halted idle", o_halted_flag, 32'h1);
		rs(32'h1000);
		wrap_up();
	end
endmodule
`default_nettype wire
